/* File: common/lpw_cfg.svh */
// Offsets, field positions, reset values and timing counts for the LCD pin enable block
`ifndef LPW_CFG_SVH
`define LPW_CFG_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define LPW_ADDR_CTRL0 4'h0
`define LPW_ADDR_PEN0 4'h1
`define LPW_ADDR_BP0 4'h5
`define LPW_ADDR_CTRL1 4'h9
`define LPW_ADDR_STAT 4'ha
// ----------------------------------------
// Field positions and resets
// ----------------------------------------
`define LPW_BIT_EN 7
`define LPW_BIT_SRC 6
`define LPW_BIT_WAI 0
`define LPW_CTRL0_RST 8'h00
`define LPW_CTRL1_RST 8'h00
// Frame length in waveform clock ticks
`define LPW_FRAME_TICKS 16'h0100
`endif

/* File: common/lpw_pkg.sv */
// Types shared by the LCD pin enable block
package lpw_pkg;
	typedef enum logic [1:0] {
		LPW_IDLE,
		LPW_RUN,
		LPW_PAUSE
	} lpw_state_t;
endpackage

/* File: logic/lpw_frame_timer.sv */
// Frame timer: counts waveform clock ticks and flags each frame boundary
`include "lpw_cfg.svh"
module lpw_frame_timer #(
	parameter logic [15:0] FRAME_TICKS = `LPW_FRAME_TICKS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic tick,
	output logic frame_end
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic next_frame_end;
	// ----------------------------------------
	// Tick counter, cleared while stopped
	// ----------------------------------------
	always_comb begin
		next_count = count;
		next_frame_end = 1'b0;
		if (!run) begin
			next_count = 16'h0000;
		end else if (tick) begin
			if (count == FRAME_TICKS - 16'h0001) begin
				next_count = 16'h0000;
				next_frame_end = 1'b1;
			end else begin
				next_count = count + 16'h0001;
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 16'h0000;
			frame_end <= 1'b0;
		end else begin
			count <= next_count;
			frame_end <= next_frame_end;
		end
	end
endmodule

/* File: logic/lpw_pin_enable.sv */
// LCD waveform enable and pin assignment control with register port
//
// Behaviour
// - Each of 32 pins drives the display or serves as general-purpose I/O.
// - After reset every pin is general-purpose I/O, following gpio_oe and gpio_out, until configured.
// - Enabled pin outputs waveform; backplane bit picks backplane or frontplane.
// - Up to eight pins may be backplane outputs; not enforced here, more than eight only sets bit 7 of the status register.
// - Master enable at control bit 7 starts the waveform generator.
// - Master enable clear disables all frontplane and backplane outputs.
// - Master enable clear stops the waveform clocks.
// - Wait-disable set stops clocks and driver during wait mode.
// - Control bit 6 picks oscillator clock when clear, alternate when set.
//
// Added by the designer: the strobed register port and the address map.
`include "lpw_cfg.svh"
module lpw_pin_enable #(
	parameter int PINS = 32,
	parameter int MAX_BP = 8,
	parameter logic [15:0] FRAME_TICKS = `LPW_FRAME_TICKS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic wait_mode,
	input wire logic osc_tick,
	input wire logic alt_tick,
	input wire logic [PINS-1:0] gpio_out,
	input wire logic [PINS-1:0] gpio_oe,
	output logic [PINS-1:0] lcd_drive,
	output logic [PINS-1:0] lcd_backplane,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pin_out,
	output logic wave_clk_en,
	output logic wave_tick
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] display_control_zero;
	logic [7:0] ctrl1;
	logic [PINS-1:0] pin_drive_enable_bits;
	logic [PINS-1:0] backplane_select_bits;
	logic [PINS-1:0] act_pen;
	logic [PINS-1:0] act_bp;
	logic [7:0] next_ctrl0;
	logic [7:0] next_ctrl1;
	logic [PINS-1:0] next_pen;
	logic [PINS-1:0] next_bp;
	logic [7:0] next_rdata;
	logic run;
	logic frame_end;
	logic tick_sel;
	lpw_pkg::lpw_state_t state;
	lpw_pkg::lpw_state_t next_state;
	logic next_clk_en;
	logic next_tick;
	logic [PINS-1:0] next_act_pen;
	logic [PINS-1:0] next_act_bp;
	logic [PINS-1:0] next_drive;
	logic [PINS-1:0] next_bpo;
	logic [PINS-1:0] next_oe;
	logic [PINS-1:0] next_out;
	logic [7:0] bp_count;
	// Backplane population count, reported so software can respect the limit
	always_comb begin
		bp_count = 8'h00;
		for (int i = 0; i < PINS; i++) begin
			if (backplane_select_bits[i] && pin_drive_enable_bits[i]) begin
				bp_count = bp_count + 8'h01;
			end
		end
	end
	// ----------------------------------------
	// Register writes and reads
	// ----------------------------------------
	always_comb begin
		next_ctrl0 = display_control_zero;
		next_ctrl1 = ctrl1;
		next_pen = pin_drive_enable_bits;
		next_bp = backplane_select_bits;
		next_rdata = 8'h00;
		if (wr) begin
			if (addr == `LPW_ADDR_CTRL0) begin
				// Only the enable changes while enabled; other fields are locked
				if (display_control_zero[`LPW_BIT_EN]) begin
					next_ctrl0[`LPW_BIT_EN] = wdata[`LPW_BIT_EN];
				end else begin
					next_ctrl0 = wdata;
				end
			end else if (addr >= `LPW_ADDR_PEN0 && addr < `LPW_ADDR_BP0) begin
				next_pen[8*(addr-`LPW_ADDR_PEN0) +: 8] = wdata;
			end else if (addr >= `LPW_ADDR_BP0 && addr < `LPW_ADDR_CTRL1) begin
				next_bp[8*(addr-`LPW_ADDR_BP0) +: 8] = wdata;
			end else if (addr == `LPW_ADDR_CTRL1) begin
				next_ctrl1 = wdata;
			end
		end
		if (rd) begin
			if (addr == `LPW_ADDR_CTRL0) begin
				next_rdata = display_control_zero;
			end else if (addr >= `LPW_ADDR_PEN0 && addr < `LPW_ADDR_BP0) begin
				next_rdata = pin_drive_enable_bits[8*(addr-`LPW_ADDR_PEN0) +: 8];
			end else if (addr >= `LPW_ADDR_BP0 && addr < `LPW_ADDR_CTRL1) begin
				next_rdata = backplane_select_bits[8*(addr-`LPW_ADDR_BP0) +: 8];
			end else if (addr == `LPW_ADDR_CTRL1) begin
				next_rdata = ctrl1;
			end else if (addr == `LPW_ADDR_STAT) begin
				next_rdata = {(bp_count > 8'(MAX_BP)), 5'h00, state};
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			display_control_zero <= `LPW_CTRL0_RST;
			ctrl1 <= `LPW_CTRL1_RST;
			pin_drive_enable_bits <= '0;
			backplane_select_bits <= '0;
			rdata <= 8'h00;
		end else begin
			display_control_zero <= next_ctrl0;
			ctrl1 <= next_ctrl1;
			pin_drive_enable_bits <= next_pen;
			backplane_select_bits <= next_bp;
			rdata <= next_rdata;
		end
	end
	// ----------------------------------------
	// Waveform clock gating and pin control
	// ----------------------------------------
	// Source mux: oscillator when clear, alternate when set
	assign tick_sel = display_control_zero[`LPW_BIT_SRC] ? alt_tick : osc_tick;
	assign run = (state == lpw_pkg::LPW_RUN);
	lpw_frame_timer #(
		.FRAME_TICKS(FRAME_TICKS)
	) u_frame (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(run),
		.tick(tick_sel),
		.frame_end(frame_end)
	);
	always_comb begin
		next_state = state;
		next_act_pen = act_pen;
		next_act_bp = act_bp;
		case (state)
			lpw_pkg::LPW_IDLE: begin
				if (display_control_zero[`LPW_BIT_EN]) begin
					next_state = lpw_pkg::LPW_RUN;
					// Enabling during wait must not flash the glass for a cycle
					if (wait_mode && ctrl1[`LPW_BIT_WAI]) begin
						next_state = lpw_pkg::LPW_PAUSE;
					end
					// Start with current settings; no frame is in flight yet
					next_act_pen = pin_drive_enable_bits;
					next_act_bp = backplane_select_bits;
				end
			end
			lpw_pkg::LPW_RUN: begin
				if (!display_control_zero[`LPW_BIT_EN]) begin
					next_state = lpw_pkg::LPW_IDLE;
				end else if (wait_mode && ctrl1[`LPW_BIT_WAI]) begin
					next_state = lpw_pkg::LPW_PAUSE;
				end else if (frame_end) begin
					// Staged copy avoids mid-frame glitches on the glass
					next_act_pen = pin_drive_enable_bits;
					next_act_bp = backplane_select_bits;
				end
			end
			lpw_pkg::LPW_PAUSE: begin
				if (!display_control_zero[`LPW_BIT_EN]) begin
					next_state = lpw_pkg::LPW_IDLE;
				end else if (!(wait_mode && ctrl1[`LPW_BIT_WAI])) begin
					next_state = lpw_pkg::LPW_RUN;
				end
			end
			default: next_state = lpw_pkg::LPW_IDLE;
		endcase
		next_clk_en = (next_state == lpw_pkg::LPW_RUN);
		next_tick = run && tick_sel;
		for (int i = 0; i < PINS; i++) begin
			// Pin owned by display when enabled; else GPIO, following gpio_oe and gpio_out
			if (next_act_pen[i]) begin
				next_drive[i] = next_clk_en;
				next_bpo[i] = next_clk_en && next_act_bp[i];
				next_oe[i] = 1'b0;
				next_out[i] = 1'b0;
			end else begin
				next_drive[i] = 1'b0;
				next_bpo[i] = 1'b0;
				next_oe[i] = gpio_oe[i];
				next_out[i] = gpio_out[i];
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= lpw_pkg::LPW_IDLE;
			act_pen <= '0;
			act_bp <= '0;
			wave_clk_en <= 1'b0;
			wave_tick <= 1'b0;
			lcd_drive <= '0;
			lcd_backplane <= '0;
			pin_oe <= '0;
			pin_out <= '0;
		end else begin
			state <= next_state;
			act_pen <= next_act_pen;
			act_bp <= next_act_bp;
			wave_clk_en <= next_clk_en;
			wave_tick <= next_tick;
			lcd_drive <= next_drive;
			lcd_backplane <= next_bpo;
			pin_oe <= next_oe;
			pin_out <= next_out;
		end
	end
endmodule

/* File: bench/lpw_pin_enable_assertions.sv */
// Port checker for the LCD pin enable block
module lpw_chk #(
	parameter int PINS = 32
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic wait_mode,
	input wire logic osc_tick,
	input wire logic alt_tick,
	input wire logic [PINS-1:0] gpio_oe,
	input wire logic [PINS-1:0] lcd_drive,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic wave_clk_en,
	input wire logic wave_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic en, src, wai, next_en, next_src, next_wai;
	logic sel_tick;
	// Tick line the mirrored source bit selects
	assign sel_tick = src ? alt_tick : osc_tick;
	// Mirror of enable, source and wait bits; source locked while enabled
	always_comb begin
		next_en = en;
		next_src = src;
		next_wai = wai;
		if (wr && addr == 4'h0 && !en) next_src = wdata[6];
		if (wr && addr == 4'h0) next_en = wdata[7];
		if (wr && addr == 4'h9) next_wai = wdata[0];
	end
	// Mirror registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) {en, src, wai} <= 3'h0;
		else {en, src, wai} <= {next_en, next_src, next_wai};
	end
	a_start_run: assert property (wr && addr == 4'h0 && wdata[7] && !wait_mode
		|-> ##2 wave_clk_en) else $error("enable did not start run");
	a_stop_run: assert property (wr && addr == 4'h0 && !wdata[7]
		|-> ##2 (!wave_clk_en && lcd_drive == '0)) else $error("disable did not stop");
	a_wait_pause: assert property (wait_mode && wai [*3]
		|-> !wave_clk_en && lcd_drive == '0) else $error("wait did not pause");
	a_idle_quiet: assert property (!wave_clk_en [*2]
		|-> lcd_drive == '0 && !wave_tick) else $error("idle pins or ticks");
	a_owner_excl: assert property ((lcd_drive & pin_oe) == '0)
		else $error("pin owned twice");
	a_gpio_follow: assert property ((pin_oe & ~$past(gpio_oe)) == '0)
		else $error("pin driven without gpio enable");
	a_tick_source: assert property (wave_clk_en && $past(wave_clk_en)
		|-> wave_tick == $past(sel_tick)) else $error("wrong tick");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule
bind lpw_pin_enable lpw_chk #(.PINS(PINS)) u_lpw_chk (.*);

/* File: bench/lpw_glass.sv */
// Glass model: resolves each pad from GPIO, segment drive or float
module lpw_glass #(
	parameter int PINS = 32
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] lcd_drive,
	input wire logic [PINS-1:0] lcd_backplane,
	input wire logic wave_tick,
	output logic [PINS-1:0] pad
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ph;
	// Floating pads flip each cycle so a stale level never reads as driven
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ph <= 1'b0;
			pad <= '0;
		end else begin
			ph <= ph ^ wave_tick;
			pad <= (pin_oe & pin_out) | (lcd_drive & ~(lcd_backplane ^ {PINS{ph}}))
				| (~pin_oe & ~lcd_drive & ~pad);
		end
	end
endmodule

/* File: bench/tb.sv */
// Testbench for the LCD pin enable block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_n = 0, wr = 0, rd = 0, wait_mode = 0, osc_tick = 0, alt_tick = 0;
	logic [3:0] addr = 0;
	logic [7:0] wdata = 0, rdata;
	logic [31:0] gpio_out = 32'h5a5a_a5a5, gpio_oe = 32'hffff_00ff;
	logic [31:0] lcd_drive, lcd_backplane, pin_oe, pin_out, pad;
	logic wave_clk_en, wave_tick;
	int fails = 0, n_checks = 0;
	// Short frames keep the run brief
	lpw_pin_enable #(.FRAME_TICKS(16'h0004)) u_lpw_pin_enable (.*);
	lpw_glass u_lpw_glass (.*);
	always #4 mclk = ~mclk;
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge mclk);
	endtask
	// A gap cycle after each access avoids re-driving a strobe in one step
	task automatic wreg(logic [3:0] a, logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
		cyc(1);
	endtask
	task automatic rreg(logic [3:0] a, logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		#1 chk(32'(rdata), 32'(d));
		cyc(1);
	endtask
	task automatic tick(logic alt);
		alt_tick <= alt;
		osc_tick <= !alt;
		cyc(1);
		alt_tick <= 1'b0;
		osc_tick <= 1'b0;
		#1 chk(32'(wave_tick), 32'h0000_0001);
		cyc(1);
	endtask
	task automatic summarize();
		$display("fails=%0d n_checks=%0d", fails, n_checks);
		if (fails == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Watchdog well past the expected run length
	initial begin
		#20000;
		fails++;
		summarize();
	end
	// Main sequence
	initial begin
		cyc(1);
		#1 chk(lcd_drive | pin_oe | 32'(wave_clk_en), 0);
		cyc(1);
		rst_n <= 1'b1;
		cyc(2);
		#1 chk(pin_oe, gpio_oe);
		chk(pad & gpio_oe, gpio_out & gpio_oe);
		rreg(4'h0, 8'h00);
		rreg(4'h9, 8'h00);
		rreg(4'hf, 8'h00);
		wreg(4'h1, 8'h0f);
		wreg(4'h2, 8'h0f);
		wreg(4'h5, 8'h0f);
		rreg(4'h1, 8'h0f);
		wreg(4'h0, 8'h80);
		cyc(1);
		#1 chk(lcd_drive, 32'h0f0f);
		chk(lcd_backplane, 32'h000f);
		chk(pin_oe, gpio_oe & ~32'h0f0f);
		wreg(4'h0, 8'hc0);
		rreg(4'h0, 8'h80);
		wreg(4'h2, 8'hff);
		wreg(4'h5, 8'hff);
		wreg(4'h6, 8'h01);
		#1 chk(lcd_drive, 32'h0f0f);
		repeat (4) tick(1'b0);
		cyc(2);
		#1 chk(lcd_drive, 32'hff0f);
		chk(lcd_backplane, 32'h010f);
		rreg(4'ha, 8'h01);
		wreg(4'h6, 8'hff);
		rreg(4'ha, 8'h81);
		wreg(4'h9, 8'h01);
		wait_mode <= 1'b1;
		cyc(3);
		#1 chk(lcd_drive | 32'(wave_clk_en), 0);
		cyc(1);
		wait_mode <= 1'b0;
		cyc(3);
		#1 chk(32'(wave_clk_en), 1);
		wreg(4'h0, 8'h00);
		cyc(1);
		#1 chk(lcd_drive | 32'(wave_clk_en), 0);
		chk(pin_oe, gpio_oe & ~32'hff0f);
		wreg(4'h0, 8'h40);
		wreg(4'h0, 8'hc0);
		cyc(1);
		tick(1'b1);
		osc_tick <= 1'b1;
		cyc(1);
		osc_tick <= 1'b0;
		#1 chk(32'(wave_tick), 0);
		cyc(1);
		rst_n <= 1'b0;
		cyc(1);
		#1 chk(lcd_drive | pin_oe | 32'(wave_clk_en), 0);
		summarize();
	end
endmodule
